// *** shared/sss_pkg.sv ***
/*
  Shared constants and types of the packed shift and subtract datapath:
  instruction fields, register offsets, reset values and carriers.
  Assumes a 32-bit instruction word and 64-bit general registers.
*/
package sss_pkg;

  // Instruction fields
  localparam int MAJOR_LSB = 26;
  localparam int SRC1_LSB  = 21;
  localparam int SRC2_LSB  = 16;
  localparam int DEST_LSB  = 11;
  localparam int SUBOP_LSB = 6;
  localparam int FUNC_LSB  = 0;

  // Encodings
  localparam logic [5:0] OP_EXT_MAJOR   = 6'h1f;
  localparam logic [5:0] FUNC_OCT_SHIFT = 6'h17;
  localparam logic [5:0] FUNC_QUAD_SHFT = 6'h13;
  localparam logic [5:0] FUNC_QUAD_ARTH = 6'h10;
  localparam logic [4:0] SUBOP_SHRV_B   = 5'h03;
  localparam logic [4:0] SUBOP_SHRV_H   = 5'h1b;
  localparam logic [4:0] SUBOP_SUB_WRAP = 5'h0b;
  localparam logic [4:0] SUBOP_SUB_SAT  = 5'h0f;

  // Saturation limits
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  // Register map, byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_DSPCTL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Field positions and reset values
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_REV2_BIT = 1;
  localparam int OUFLAG_BIT    = 20;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0003;
  localparam logic [31:0] DSPCTL_RESET = 32'h0000_0000;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_SHR_OB  = 3'b001,
    OP_SHR_PH  = 3'b010,
    OP_SHR_QB  = 3'b011,
    OP_SHR_QH  = 3'b100
  } sss_shift_op_t;

  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] shift_or_first_source;
    logic [63:0] data_or_second_source;
  } sss_issue_t;

  typedef struct packed {
    logic [4:0]  dest;
    logic [63:0] value;
  } sss_result_t;

endpackage

// *** hw/sss_shift_unit.sv ***
/*
  Lane-wise variable logical right shifter for bytes and halfwords.
  Assumes the caller decodes the operation; purely combinational.
*/
`timescale 1ns/1ns
module sss_shift_unit
  import sss_pkg::*;
(
  input  wire logic [63:0]   data,
  input  wire logic [3:0]    count,
  input  sss_pkg::sss_shift_op_t op,
  output      logic [63:0]   result
);

  function automatic logic [7:0] shr8(input logic [7:0] a,
                                      input logic [2:0] s);
    shr8 = a >> s;
  endfunction

  function automatic logic [15:0] shr16(input logic [15:0] a,
                                        input logic [3:0] s);
    shr16 = a >> s;
  endfunction

  logic [63:0] bytes_r;
  logic [63:0] halves_r;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bytes_r[i*8 +: 8] = shr8(data[i*8 +: 8], count[2:0]);
    end
    for (int j = 0; j < 4; j++) begin
      halves_r[j*16 +: 16] = shr16(data[j*16 +: 16], count);
    end
  end

  always_comb begin
    unique case (op)
      OP_SHR_OB: result = bytes_r;
      OP_SHR_QB: result = {{32{bytes_r[31]}}, bytes_r[31:0]};
      OP_SHR_PH: result = {{32{halves_r[31]}}, halves_r[31:0]};
      OP_SHR_QH: result = halves_r;
      default:   result = 64'h0;
    endcase
  end

endmodule

// *** hw/sss_sub_unit.sv ***
/*
  Q15 halfword-pair subtractor, wrapping or saturating per lane.
  Assumes operands in the low word; purely combinational.
*/
`timescale 1ns/1ns
module sss_sub_unit
  import sss_pkg::*;
(
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  input  wire logic        saturate,
  output      logic [63:0] result,
  output      logic        overflow
);

  function automatic logic [16:0] diff17(input logic [15:0] x,
                                         input logic [15:0] y);
    diff17 = {x[15], x} - {y[15], y};
  endfunction

  logic [16:0] d [2];
  logic [15:0] lane [2];
  logic [1:0]  ov;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      d[i] = diff17(a[i*16 +: 16], b[i*16 +: 16]);
      ov[i] = d[i][16] ^ d[i][15];
      if (saturate && ov[i]) begin
        lane[i] = d[i][16] ? SAT_NEG : SAT_POS;
      end else begin
        lane[i] = d[i][15:0];
      end
    end
    overflow = |ov;
    result = {{32{lane[1][15]}}, lane[1], lane[0]};
  end

endmodule

// *** hw/simd_shift_sub_datapath.sv ***
/*
  Execution stage for packed variable right shifts and Q15 pair
  subtraction, with an AHB-Lite slave for control, the DSP control
  register and status. Assumes issue logic on the same clock presents
  one instruction with its operand values per cycle and that the
  register file takes the writeback one cycle later.
*/
// Functional notes
// - Eight-byte shift: major 011111, subop 00011, func 010111.
// - Each of eight bytes shifts right alone, zero filled.
// - Eight-byte count is the low three bits of the first source.
// - Halfword-pair shift: major 011111, subop 11011, func 010011.
// - Two low halfwords shift right alone, zero filled.
// - Halfword shifts count with the low four bits, zero to fifteen.
// - Halfword-pair result bit 15 of upper lane fills top 32 bits.
// - Four-byte shift: major 011111, subop 00011, func 010011.
// - Four low bytes shift right alone, zero filled.
// - Four-byte result top bit fills the upper 32 bits.
// - Four-byte count is the low three bits of the first source.
// - Four-halfword shift: major 011111, subop 11011, func 010111.
// - Four halfword lanes shift alone; full 64-bit result, no extension.
// - Wrapping pair subtract: major 011111, subop 01011, func 010000.
// - Saturating pair subtract: major 011111, subop 01111, func 010000.
// - Subtract each low second-source halfword from the first source.
// - Wrapping form writes the wrapped 16-bit difference.
// - Saturating form clamps to 7fff on overflow, 8000 on underflow.
// - Upper lane result sign fills the top 32 destination bits.
// - Any lane overflow sets sticky flag bit 20; hardware never clears.
// - Only reserved or disabled exceptions; none from operand values.
// - Overflow when bit 16 of 17-bit difference differs from bit 15.
`timescale 1ns/1ns
module simd_shift_sub_datapath
  import sss_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                issue_valid,
  input  sss_pkg::sss_issue_t      issue,
  output      logic                wb_valid,
  output sss_pkg::sss_result_t     wb,
  output      logic                exc_reserved,
  output      logic                exc_dsp_disabled,
  output      logic                ouflag,
  input  wire logic                hsel,
  input  wire logic [ADDR_W-1:0]   haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output      logic                hreadyout,
  output      logic [31:0]         hrdata,
  output      logic                hresp
);

  function automatic logic match(input logic [31:0] ins,
                                 input logic [4:0]  subop,
                                 input logic [5:0]  func);
    match = (ins[MAJOR_LSB +: 6] == OP_EXT_MAJOR) &&
            (ins[SUBOP_LSB +: 5] == subop) &&
            (ins[FUNC_LSB +: 6] == func);
  endfunction

  // Decode
  wire logic dec_ob = match(issue.instr, SUBOP_SHRV_B,
                            FUNC_OCT_SHIFT);
  wire logic dec_ph = match(issue.instr, SUBOP_SHRV_H,
                            FUNC_QUAD_SHFT);
  wire logic dec_qb = match(issue.instr, SUBOP_SHRV_B,
                            FUNC_QUAD_SHFT);
  wire logic dec_qh = match(issue.instr, SUBOP_SHRV_H,
                            FUNC_OCT_SHIFT);
  wire logic dec_sw = match(issue.instr, SUBOP_SUB_WRAP,
                            FUNC_QUAD_ARTH);
  wire logic dec_ss = match(issue.instr, SUBOP_SUB_SAT,
                            FUNC_QUAD_ARTH);

  wire logic dec_shift = dec_ob | dec_ph | dec_qb | dec_qh;
  wire logic dec_sub   = dec_sw | dec_ss;
  wire logic dec_any   = dec_shift | dec_sub;

  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] dspctl_q;
  logic [31:0] dspctl_d;
  logic [15:0] commit_cnt_q;
  logic        seen_ri_q;
  logic        seen_dis_q;

  // Exceptions depend on the opcode and control bits only
  wire logic rev2_op = dec_ph | dec_qh;
  wire logic ri_hit  = issue_valid & rev2_op &
                       ~ctrl_q[CTRL_REV2_BIT];
  wire logic dis_hit = issue_valid & dec_any & ~ri_hit &
                       ~ctrl_q[CTRL_EN_BIT];
  wire logic commit  = issue_valid & dec_any & ~ri_hit & ~dis_hit;

  // Datapath
  sss_shift_op_t shift_op;
  logic [63:0]   shift_res;
  logic [63:0]   sub_res;
  logic          sub_ovf;

  assign shift_op = dec_ob ? OP_SHR_OB :
                    dec_ph ? OP_SHR_PH :
                    dec_qb ? OP_SHR_QB :
                    dec_qh ? OP_SHR_QH : OP_NONE;

  sss_shift_unit u_shift (
    .data   (issue.data_or_second_source),
    .count  (issue.shift_or_first_source[3:0]),
    .op     (shift_op),
    .result (shift_res)
  );

  sss_sub_unit u_sub (
    .a        (issue.shift_or_first_source[31:0]),
    .b        (issue.data_or_second_source[31:0]),
    .saturate (dec_ss),
    .result   (sub_res),
    .overflow (sub_ovf)
  );

  wire logic [63:0] exec_value = dec_sub ? sub_res : shift_res;
  wire logic [4:0]  exec_dest  = issue.instr[DEST_LSB +: 5];
  wire logic        flag_set   = commit & dec_sub & sub_ovf;

  // Bus slave
  wire logic bus_take  = hsel & hready & htrans[1];
  wire logic bus_wr_ok = bus_take & hwrite & (hsize == HSIZE_WORD);
  logic              wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;

  wire logic wr_ctrl   = wr_pend_q && (wr_addr_q == ADDR_W'(ADDR_CTRL));
  wire logic wr_dspctl = wr_pend_q &&
                         (wr_addr_q == ADDR_W'(ADDR_DSPCTL));

  wire logic [31:0] status_word = {commit_cnt_q, 14'h0,
                                   seen_ri_q, seen_dis_q};
  wire logic [31:0] rd_word =
    (haddr == ADDR_W'(ADDR_CTRL))   ? ctrl_q   :
    (haddr == ADDR_W'(ADDR_DSPCTL)) ? dspctl_q :
    (haddr == ADDR_W'(ADDR_STATUS)) ? status_word : 32'h0;

  // Software write to the flag loses to a hardware set
  always_comb begin
    ctrl_d = wr_ctrl ? hwdata : ctrl_q;
    dspctl_d = wr_dspctl ? hwdata : dspctl_q;
    if (flag_set) begin
      dspctl_d[OUFLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= bus_wr_ok;
      wr_addr_q <= bus_take ? haddr : wr_addr_q;
      hrdata    <= (bus_take && !hwrite) ? rd_word : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= CTRL_RESET;
      dspctl_q <= DSPCTL_RESET;
      ouflag   <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      dspctl_q <= dspctl_d;
      ouflag   <= dspctl_d[OUFLAG_BIT];
    end
  end

  // Writeback stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid         <= 1'b0;
      wb               <= '0;
      exc_reserved     <= 1'b0;
      exc_dsp_disabled <= 1'b0;
    end else begin
      wb_valid         <= commit;
      wb               <= commit ? {exec_dest, exec_value} : wb;
      exc_reserved     <= ri_hit;
      exc_dsp_disabled <= dis_hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commit_cnt_q <= 16'h0;
      seen_ri_q    <= 1'b0;
      seen_dis_q   <= 1'b0;
    end else begin
      commit_cnt_q <= commit_cnt_q + 16'(commit);
      seen_ri_q    <= seen_ri_q | ri_hit;
      seen_dis_q   <= seen_dis_q | dis_hit;
    end
  end

  // Checks
  property p_ob_lane;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_ob) |=>
      (wb.value[63:56] == ($past(issue.data_or_second_source[63:56])
        >> $past(issue.shift_or_first_source[2:0])));
  endproperty
  a_ob_lane: assert property (p_ob_lane)
    else $error("eight-byte lane shift wrong");

  property p_ob_decode;
    @(posedge clock) disable iff (!rst_n)
    (issue_valid && ctrl_q[CTRL_EN_BIT] &&
     issue.instr[31:26] == 6'h1f && issue.instr[10:6] == 5'h03 &&
     issue.instr[5:0] == 6'h17) |=>
      wb_valid && wb.dest == $past(issue.instr[15:11]);
  endproperty
  a_ob_decode: assert property (p_ob_decode)
    else $error("eight-byte shift not committed");

  property p_ph_ext;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_ph) |=>
      wb.value[63:32] == {32{wb.value[31]}} &&
      wb.value[15:0] == ($past(issue.data_or_second_source[15:0])
        >> $past(issue.shift_or_first_source[3:0]));
  endproperty
  a_ph_ext: assert property (p_ph_ext)
    else $error("halfword pair result wrong");

  property p_qb_ext;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_qb) |=>
      wb.value[63:32] == {32{wb.value[31]}} &&
      wb.value[31:24] == ($past(issue.data_or_second_source[31:24])
        >> $past(issue.shift_or_first_source[2:0]));
  endproperty
  a_qb_ext: assert property (p_qb_ext)
    else $error("four-byte result wrong");

  property p_qh_full;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_qh) |=>
      wb.value[63:48] == ($past(issue.data_or_second_source[63:48])
        >> $past(issue.shift_or_first_source[3:0]));
  endproperty
  a_qh_full: assert property (p_qh_full)
    else $error("four-halfword top lane wrong");

  property p_wrap;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_sw) |=>
      wb.value[15:0] == 16'($past(issue.shift_or_first_source[15:0])
        - $past(issue.data_or_second_source[15:0]));
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrapping difference wrong");

  property p_sat_pos;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_ss && issue.shift_or_first_source[15:0] == 16'h7fff &&
     issue.data_or_second_source[15:0] == 16'hffff) |=>
      wb.value[15:0] == 16'h7fff;
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("positive clamp missing");

  property p_sat_neg;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_ss && issue.shift_or_first_source[31:16] == 16'h8000
     && issue.data_or_second_source[31:16] == 16'h0001) |=>
      wb.value[31:16] == 16'h8000;
  endproperty
  a_sat_neg: assert property (p_sat_neg)
    else $error("negative clamp missing");

  property p_sub_ext;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_sub) |=> wb.value[63:32] == {32{wb.value[31]}};
  endproperty
  a_sub_ext: assert property (p_sub_ext)
    else $error("subtract sign extension wrong");

  property p_ob_count;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_ob) |=>
      wb.value[7:0] == ($past(issue.data_or_second_source[7:0])
        >> $past(issue.shift_or_first_source[2:0]));
  endproperty
  a_ob_count: assert property (p_ob_count)
    else $error("eight-byte count wrong");

  property p_flag_set;
    @(posedge clock) disable iff (!rst_n)
    (commit && dec_sw && issue.shift_or_first_source[31:16] == 16'h8000
     && issue.data_or_second_source[31:16] == 16'h0001) |=>
      ouflag && dspctl_q[20];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("overflow flag not set");

  property p_flag_sticky;
    @(posedge clock) disable iff (!rst_n)
    (dspctl_q[20] && !wr_dspctl) |=> dspctl_q[20] [*1];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag dropped");

  property p_flag_hold;
    @(posedge clock) disable iff (!rst_n)
    (!commit && !wr_dspctl) |=> dspctl_q == $past(dspctl_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("control register changed without cause");

  property p_no_data_exc;
    @(posedge clock) disable iff (!rst_n)
    (issue_valid && dec_any && ctrl_q[0] && ctrl_q[1]) |=>
      !exc_reserved && !exc_dsp_disabled && wb_valid;
  endproperty
  a_no_data_exc: assert property (p_no_data_exc)
    else $error("exception raised on enabled op");

  property p_dis_exc;
    @(posedge clock) disable iff (!rst_n)
    (issue_valid && dec_sub && !ctrl_q[0]) |=>
      exc_dsp_disabled && !wb_valid;
  endproperty
  a_dis_exc: assert property (p_dis_exc)
    else $error("disabled exception missing");

  property p_rsv_exc;
    @(posedge clock) disable iff (!rst_n)
    (issue_valid && (dec_ph || dec_qh) && !ctrl_q[1]) |=>
      exc_reserved && !exc_dsp_disabled && !wb_valid;
  endproperty
  a_rsv_exc: assert property (p_rsv_exc)
    else $error("reserved exception missing");

endmodule

// *** testbench/sss_regfile_model.sv ***
/*
  Register file stand-in on the far side of the datapath: takes every
  writeback and counts commits.
  Assumes the datapath's clock and reset.
*/
`timescale 1ns/1ns
module sss_regfile_model
  import sss_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            wb_valid,
  input  sss_pkg::sss_result_t wb,
  output      logic [15:0]     commits,
  output      logic [63:0]     r3_value
);
  import sss_pkg::*;

  logic [63:0] regs [32];

  assign r3_value = regs[3];

  // Packed values are stored whole, as committed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commits <= 16'h0000;
    end else if (wb_valid) begin
      regs[wb.dest] <= wb.value;
      commits       <= commits + 16'h0001;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the packed shift and subtract datapath.
  Assumes one core clock, zero-wait AHB-Lite control bus.
*/
`timescale 1ns/1ns
module tb_top;
  import sss_pkg::*;

  localparam logic [63:0] DAT = 64'h8f81_40ff_c37e_0190;

  logic               clock;
  logic               rst_n;
  logic               issue_valid;
  sss_issue_t         issue;
  logic               wb_valid;
  sss_result_t        wb;
  logic               exc_reserved;
  logic               exc_dsp_disabled;
  logic               ouflag;
  logic               hsel;
  logic [11:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic               hready;
  logic               hreadyout;
  logic [31:0]        hrdata;
  logic               hresp;
  logic [15:0]        commits_m;
  logic [15:0]        commits;
  logic [63:0]        r3_m;
  logic [63:0]        last_ev;
  int                 failures;
  int                 checked;
  logic [63:0]        sa [3];
  logic [63:0]        sb [3];

  assign hready = hreadyout;

  simd_shift_sub_datapath dut (
    .clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue(issue), .wb_valid(wb_valid), .wb(wb),
    .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled),
    .ouflag(ouflag), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
  );

  sss_regfile_model model (
    .clock(clock), .rst_n(rst_n), .wb_valid(wb_valid), .wb(wb),
    .commits(commits_m), .r3_value(r3_m)
  );

  task automatic end_of_test();
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    chk({63'h0, n >= 50}, 64'h0);
  endtask

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({63'h0, hresp}, 64'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk({32'h0, x}, {32'h0, e});
  endtask

  function automatic logic [31:0] mk(input logic [4:0] so,
                                     input logic [5:0] fn);
    return {6'h1f, 5'h01, 5'h02, 5'h03, so, fn};
  endfunction

  // Expected flags {wb_valid, reserved, disabled, ouflag}
  task automatic do_op(input logic [31:0] ins, input logic [63:0] a,
                       input logic [63:0] b, input logic [3:0] e,
                       input logic [63:0] ev);
    issue_valid <= 1'b1;
    issue       <= '{ins, a, b};
    @(posedge clock);
    issue_valid <= 1'b0;
    @(posedge clock);
    chk({60'h0, wb_valid, exc_reserved, exc_dsp_disabled, ouflag},
        {60'h0, e});
    if (e[3]) begin
      chk(wb.value, ev);
      chk({59'h0, wb.dest}, 64'h3);
      commits++;
      last_ev = ev;
    end
  endtask

  function automatic logic [63:0] exp_shift(input int k,
      input logic [63:0] d, input logic [3:0] c);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 8; i++) begin
      if (k == 0 || (k == 2 && i < 4)) r[8*i+:8] = d[8*i+:8] >> c[2:0];
    end
    for (int i = 0; i < 4; i++) begin
      if (k == 3 || (k == 1 && i < 2)) r[16*i+:16] = d[16*i+:16] >> c;
    end
    if (k == 1 || k == 2) r[63:32] = {32{r[31]}};
    return r;
  endfunction

  function automatic logic [64:0] exp_sub(input logic [63:0] a,
      input logic [63:0] b, input logic s);
    logic [16:0] d;
    logic [15:0] h [2];
    logic        ov;
    ov = 1'b0;
    for (int i = 0; i < 2; i++) begin
      d = {a[16*i+15], a[16*i+:16]} - {b[16*i+15], b[16*i+:16]};
      h[i] = d[15:0];
      if (d[16] != d[15]) begin
        ov = 1'b1;
        if (s) h[i] = d[16] ? 16'h8000 : 16'h7fff;
      end
    end
    return {ov, {32{h[1][15]}}, h[1], h[0]};
  endfunction

  task automatic shop(input int k, input logic [4:0] so,
                      input logic [5:0] fn, input logic [3:0] cv);
    do_op(mk(so, fn), {60'ha5a5a5a5a5a5a5a, cv}, DAT, 4'h8,
          exp_shift(k, DAT, cv));
  endtask

  task automatic sbop(input logic s, input int p, inout logic fl);
    logic [64:0] r;
    r = exp_sub(sa[p], sb[p], s);
    fl = fl | r[64];
    do_op(mk(s ? 5'h0f : 5'h0b, 6'h10), sa[p], sb[p], {3'h4, fl},
          r[63:0]);
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    end_of_test();
  end

  initial begin
    logic fl;
    rst_n = 1'b0; issue_valid = 1'b0; issue = '0; hsel = 1'b0;
    haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; failures = 0; checked = 0; commits = 16'h0;
    sa = '{64'hdead_beef_1234_0005, 64'h1111_2222_8000_7fff,
           64'h0000_0000_1234_0005};
    sb = '{64'hffff_0000_0034_0007, 64'h3333_4444_0001_ffff,
           64'h0000_0000_0034_0007};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(ADDR_CTRL, 32'h0000_0003);
    rdc(ADDR_DSPCTL, 32'h0000_0000);
    rdc(12'h00c, 32'h0000_0000);
    wr(ADDR_STATUS, 32'hffff_ffff);
    rdc(ADDR_STATUS, 32'h0000_0000);
    for (int c = 0; c < 16; c++) begin
      shop(0, 5'h03, 6'h17, c[3:0]);
      shop(1, 5'h1b, 6'h13, c[3:0]);
      shop(2, 5'h03, 6'h13, c[3:0]);
      shop(3, 5'h1b, 6'h17, c[3:0]);
    end
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_DSPCTL, 32'h0000_0000);
      fl = 1'b0;
      for (int p = 0; p < 3; p++) begin
        sbop(s[0], p, fl);
      end
      rdc(ADDR_DSPCTL, 32'h0010_0000);
    end
    wr(ADDR_DSPCTL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001);
    do_op(mk(5'h1b, 6'h13), 64'h1, DAT, 4'h4, 64'h0);
    do_op(mk(5'h1b, 6'h17), 64'h1, DAT, 4'h4, 64'h0);
    shop(2, 5'h03, 6'h13, 4'h1);
    wr(ADDR_CTRL, 32'h0000_0000);
    do_op(mk(5'h0f, 6'h10), sa[1], sb[1], 4'h2, 64'h0);
    do_op(mk(5'h1b, 6'h13), 64'h1, DAT, 4'h4, 64'h0);
    do_op(mk(5'h03, 6'h3f), 64'h1, DAT, 4'h0, 64'h0);
    chk({48'h0, commits_m}, {48'h0, commits});
    chk(r3_m, last_ev);
    rdc(ADDR_STATUS, {commits, 16'h0003});
    end_of_test();
  end
endmodule
